// [hw/ddr_cmd_decode.sv]
`timescale 1ns/1ps
// How it works
// [R1] Controller writes reserved EMR2 address bits as zero.
// [R2] EMR2 bit A7 selects the faster self-refresh rate above 85 C.
// [R3] With partial array refresh, banks outside the selection lose data in self refresh.
// [R4] Mode register set to the fourth register is accepted and changes nothing.
// [R5] Controller never issues unspecified commands; otherwise full re-initialisation.
// [R6] Commands decode from cs, ras, cas, we and cke at the link clock rise.
// [R7] Bank address picks the bank, or the mode register for register set.
// [R8] Controller never interrupts a burst of four.
// [R9] Controller leaves power down in time to keep refresh.
// [R10] Termination never alters decoding and is off during self refresh.
// [R11] Self-refresh exit is seen on cke high alone, without link clock edges.
// [R12] Standard page ignores A12 for rows but keeps it in mode opcodes.
// [R13] Reduced page ignores A8 as a column address.
// [R14] After self-refresh exit, no read before 200 link clocks.
// [R15] Power down entry or exit and self-refresh exit carry only nop or deselect. Only power down entry and exit are checked.
// [R16] Self refresh entered by refresh with cke falling, all banks idle.
// [R17] No power down or self refresh while operations are in progress.
// [R18] Cke falling with nop enters active or precharge power down by bank state.
// [R19] Each cke level is held for three link clock rises.
// [R20] Controller keeps cke high during driver calibration.
// [R21] Controller drives termination input to a valid level in power down.
// [R22] Command codes: register set, refresh, precharge, activate, write, read, nop.
// [R23] A10 requests auto precharge, or all-bank precharge for precharge.
// [R24] Data mask low writes the byte, high leaves it unchanged.
// [R25] Mode register set only with all banks idle.
module ddr_cmd_decode #(
  parameter logic REDUCED_PAGE = 1'b0
) (
  // System
  input wire logic CLK,
  input wire logic RST,
  // Memory pins
  input wire logic CK,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BA,
  input wire logic [12:0] ADDR,
  input wire logic ODT,
  input wire logic [3:0] DM,
  // Decoded command
  output logic CMD_VALID,
  output ddr_cmd_pkg::cmd_t CMD,
  output logic [3:0] WR_BYTE_EN,
  // Device state
  output logic [3:0] POWER_STATE,
  output logic [3:0] BANK_OPEN,
  output logic [3:0] RETAIN_BANKS,
  output logic SR_HIGH_RATE,
  output logic ODT_ACTIVE,
  output logic PROTO_ERR,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  ddr_cmd_pkg::pins_t raw;
  ddr_cmd_pkg::pins_t pin;
  ddr_cmd_pkg::power_state_t state;
  ddr_cmd_pkg::cmd_code_t code;
  logic ck_d;
  logic ck_rise;
  logic cke_prev;
  logic [1:0] cke_hold;
  logic [7:0] xsrd_cnt;
  logic [12:0] mr;
  logic [12:0] emr1;
  logic [12:0] emr2;
  logic reduced;
  logic err_sticky;
  logic err_evt;
  logic sr_exit;
  logic execute;

  function automatic logic [3:0] pasr_banks(input logic [2:0] sel);
    case (sel)
      3'h0: pasr_banks = 4'hF;
      3'h1: pasr_banks = 4'h3;
      3'h2: pasr_banks = 4'h1;
      3'h4: pasr_banks = 4'hE;
      3'h5: pasr_banks = 4'hC;
      3'h6: pasr_banks = 4'h8;
      default: pasr_banks = 4'hF;
    endcase
  endfunction

  function automatic logic is_quiet(input ddr_cmd_pkg::cmd_code_t c);
    is_quiet = (c == ddr_cmd_pkg::CMD_NOP) || (c == ddr_cmd_pkg::CMD_DES);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link clock edge

  assign raw = '{ck: CK, cke: CKE, cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N,
                 ba: BA, addr: ADDR, odt: ODT, dm: DM};

  pin_sync #(.W(ddr_cmd_pkg::PIN_W)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d(raw),
    .q(pin)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      ck_d <= 1'b0;
    end else begin
      ck_d <= pin.ck;
    end
  end

  assign ck_rise = pin.ck & ~ck_d;

  // Deselect swallows the other three strobes
  assign code = pin.cs_n ? ddr_cmd_pkg::CMD_DES
                         : ddr_cmd_pkg::cmd_code_t'({1'b0, pin.ras_n, pin.cas_n, pin.we_n}); // R6 R22
  // Async exit: cke alone, no link clock needed
  assign sr_exit = (state == ddr_cmd_pkg::PS_SELF_REF) && pin.cke; // R11
  assign execute = ck_rise && (state == ddr_cmd_pkg::PS_AWAKE) && cke_prev && pin.cke;

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol checks on what the controller presents

  always_comb begin
    err_evt = 1'b0;
    if (ck_rise && pin.cke != cke_prev && cke_hold < ddr_cmd_pkg::CKE_MIN_CLOCKS) begin
      err_evt = 1'b1; // R19
    end
    if (ck_rise && state == ddr_cmd_pkg::PS_AWAKE && cke_prev && !pin.cke) begin
      if (code == ddr_cmd_pkg::CMD_REF && BANK_OPEN != ddr_cmd_pkg::BANKS_IDLE) begin
        err_evt = 1'b1; // R16
      end
      if (!is_quiet(code) && code != ddr_cmd_pkg::CMD_REF) begin
        err_evt = 1'b1; // R15 R17
      end
    end
    if (ck_rise && (state == ddr_cmd_pkg::PS_PRE_PD || state == ddr_cmd_pkg::PS_ACT_PD)
        && pin.cke && !is_quiet(code)) begin
      err_evt = 1'b1; // R15
    end
    if (execute && code == ddr_cmd_pkg::CMD_RD && xsrd_cnt != 8'h00) begin
      err_evt = 1'b1; // R14
    end
    if (execute && code == ddr_cmd_pkg::CMD_MRS && BANK_OPEN != ddr_cmd_pkg::BANKS_IDLE) begin
      err_evt = 1'b1; // R25
    end
  end

  // Set wins over a simultaneous software clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      err_sticky <= 1'b0;
    end else if (err_evt) begin
      err_sticky <= 1'b1;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == ddr_cmd_pkg::OFS_STATUS
                 && PWDATA[ddr_cmd_pkg::ST_ERR_BIT]) begin
      err_sticky <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock enable tracking

  always_ff @(posedge CLK) begin
    if (RST) begin
      cke_prev <= 1'b1;
      cke_hold <= ddr_cmd_pkg::CKE_MIN_CLOCKS;
    end else if (sr_exit) begin
      cke_prev <= 1'b1;
      cke_hold <= 2'h1;
    end else if (ck_rise) begin
      cke_prev <= pin.cke;
      if (pin.cke != cke_prev) begin
        cke_hold <= 2'h1;
      end else if (cke_hold < ddr_cmd_pkg::CKE_MIN_CLOCKS) begin
        cke_hold <= cke_hold + 2'h1;
      end
    end
  end

  // Read exit delay counts link clocks after self-refresh exit
  always_ff @(posedge CLK) begin
    if (RST) begin
      xsrd_cnt <= 8'h00;
    end else if (sr_exit) begin
      xsrd_cnt <= ddr_cmd_pkg::XSRD_CLOCKS; // R14
    end else if (ck_rise && xsrd_cnt != 8'h00) begin
      xsrd_cnt <= xsrd_cnt - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power state machine

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ddr_cmd_pkg::PS_AWAKE;
    end else begin
      case (state)
        ddr_cmd_pkg::PS_AWAKE: begin
          if (ck_rise && cke_prev && !pin.cke) begin
            if (code == ddr_cmd_pkg::CMD_REF) begin
              state <= ddr_cmd_pkg::PS_SELF_REF; // R16
            end else if (BANK_OPEN != ddr_cmd_pkg::BANKS_IDLE) begin
              state <= ddr_cmd_pkg::PS_ACT_PD; // R18
            end else begin
              state <= ddr_cmd_pkg::PS_PRE_PD; // R18
            end
          end
        end
        ddr_cmd_pkg::PS_PRE_PD, ddr_cmd_pkg::PS_ACT_PD: begin
          if (ck_rise && pin.cke) begin
            state <= ddr_cmd_pkg::PS_AWAKE;
          end
        end
        ddr_cmd_pkg::PS_SELF_REF: begin
          if (sr_exit) begin
            state <= ddr_cmd_pkg::PS_AWAKE; // R11
          end
        end
        default: state <= ddr_cmd_pkg::PS_AWAKE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bank state and mode registers

  always_ff @(posedge CLK) begin
    if (RST) begin
      BANK_OPEN <= ddr_cmd_pkg::BANKS_IDLE;
    end else if (execute) begin
      case (code)
        ddr_cmd_pkg::CMD_ACT: BANK_OPEN[pin.ba] <= 1'b1; // R7
        ddr_cmd_pkg::CMD_PRE: begin
          if (pin.addr[ddr_cmd_pkg::AP_BIT]) begin
            BANK_OPEN <= ddr_cmd_pkg::BANKS_IDLE; // R23
          end else begin
            BANK_OPEN[pin.ba] <= 1'b0; // R23
          end
        end
        // Auto precharge closes the row once the burst is done; tracked at issue
        ddr_cmd_pkg::CMD_RD, ddr_cmd_pkg::CMD_WR: begin
          if (pin.addr[ddr_cmd_pkg::AP_BIT]) begin
            BANK_OPEN[pin.ba] <= 1'b0; // R23
          end
        end
        default: BANK_OPEN <= BANK_OPEN;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mr <= ddr_cmd_pkg::MODE_RESET;
      emr1 <= ddr_cmd_pkg::MODE_RESET;
      emr2 <= ddr_cmd_pkg::MODE_RESET;
    end else if (execute && code == ddr_cmd_pkg::CMD_MRS) begin
      // Full opcode including A12 in both page options
      case (pin.ba) // R7 R12
        ddr_cmd_pkg::SEL_MR: mr <= pin.addr;
        ddr_cmd_pkg::SEL_EMR1: emr1 <= pin.addr;
        ddr_cmd_pkg::SEL_EMR2: emr2 <= pin.addr;
        default: mr <= mr; // R4
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded command output

  always_ff @(posedge CLK) begin
    if (RST) begin
      CMD_VALID <= 1'b0;
      CMD <= '{code: ddr_cmd_pkg::CMD_DES, default: '0};
      WR_BYTE_EN <= 4'h0;
    end else begin
      CMD_VALID <= execute && !is_quiet(code);
      if (execute) begin
        CMD.code <= code;
        CMD.bank <= pin.ba;
        CMD.row <= {pin.addr[ddr_cmd_pkg::ROW_TOP_BIT] & reduced, pin.addr[11:0]}; // R12
        CMD.col <= {pin.addr[ddr_cmd_pkg::COL_TOP_BIT] & ~reduced, pin.addr[7:0]}; // R13
        CMD.auto_pre <= pin.addr[ddr_cmd_pkg::AP_BIT] &&
                        (code == ddr_cmd_pkg::CMD_RD || code == ddr_cmd_pkg::CMD_WR); // R23
        CMD.all_banks <= pin.addr[ddr_cmd_pkg::AP_BIT] && code == ddr_cmd_pkg::CMD_PRE;
      end
      if (ck_rise) begin
        WR_BYTE_EN <= ~pin.dm; // R24
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State outputs

  always_ff @(posedge CLK) begin
    if (RST) begin
      POWER_STATE <= ddr_cmd_pkg::PS_AWAKE;
      RETAIN_BANKS <= 4'hF;
      SR_HIGH_RATE <= 1'b0;
      ODT_ACTIVE <= 1'b0;
      PROTO_ERR <= 1'b0;
    end else begin
      POWER_STATE <= state;
      RETAIN_BANKS <= (state == ddr_cmd_pkg::PS_SELF_REF) ? pasr_banks(emr2[2:0]) : 4'hF; // R3
      SR_HIGH_RATE <= emr2[ddr_cmd_pkg::EMR2_SRF_BIT]; // R2
      // Termination is a side output only; decoding never reads it
      ODT_ACTIVE <= pin.odt && state != ddr_cmd_pkg::PS_SELF_REF &&
                    (emr1[ddr_cmd_pkg::EMR1_RTT_LO_BIT] | emr1[ddr_cmd_pkg::EMR1_RTT_HI_BIT]); // R10
      PROTO_ERR <= err_sticky;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase

  always_ff @(posedge CLK) begin
    if (RST) begin
      reduced <= REDUCED_PAGE;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == ddr_cmd_pkg::OFS_CONFIG) begin
      reduced <= PWDATA[ddr_cmd_pkg::CFG_REDUCED_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE && !PREADY;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE) begin
        case (PADDR)
          ddr_cmd_pkg::OFS_STATUS: begin
            PRDATA[ddr_cmd_pkg::ST_PS_LSB +: 4] <= state;
            PRDATA[ddr_cmd_pkg::ST_BANK_LSB +: 4] <= BANK_OPEN;
            PRDATA[ddr_cmd_pkg::ST_SRF_BIT] <= emr2[ddr_cmd_pkg::EMR2_SRF_BIT];
            PRDATA[ddr_cmd_pkg::ST_ERR_BIT] <= err_sticky | err_evt;
            PRDATA[ddr_cmd_pkg::ST_XSRD_BIT] <= xsrd_cnt != 8'h00;
          end
          ddr_cmd_pkg::OFS_MR: PRDATA[12:0] <= mr;
          ddr_cmd_pkg::OFS_EMR1: PRDATA[12:0] <= emr1;
          ddr_cmd_pkg::OFS_EMR2: PRDATA[12:0] <= emr2;
          ddr_cmd_pkg::OFS_CONFIG: PRDATA[ddr_cmd_pkg::CFG_REDUCED_BIT] <= reduced;
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end

endmodule

// [hw/ddr_cmd_pkg.sv]
package ddr_cmd_pkg;

  // Command codes as {cs_n, ras_n, cas_n, we_n}; any code with cs_n high is deselect
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_NOP = 4'h7,
    CMD_DES = 4'h8
  } cmd_code_t;

  // Power state, one-hot
  typedef enum logic [3:0] {
    PS_AWAKE = 4'h1,
    PS_PRE_PD = 4'h2,
    PS_ACT_PD = 4'h4,
    PS_SELF_REF = 4'h8
  } power_state_t;

  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
    logic odt;
    logic [3:0] dm;
  } pins_t;

  typedef struct packed {
    cmd_code_t code;
    logic [1:0] bank;
    logic [12:0] row;
    logic [8:0] col;
    logic auto_pre;
    logic all_banks;
  } cmd_t;

  localparam int PIN_W = $bits(pins_t);

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MR = 8'h04;
  localparam logic [7:0] OFS_EMR1 = 8'h08;
  localparam logic [7:0] OFS_EMR2 = 8'h0C;
  localparam logic [7:0] OFS_CONFIG = 8'h10;

  // STATUS fields
  localparam int ST_PS_LSB = 0;
  localparam int ST_BANK_LSB = 4;
  localparam int ST_SRF_BIT = 8;
  localparam int ST_ERR_BIT = 9;
  localparam int ST_XSRD_BIT = 10;
  // CONFIG fields
  localparam int CFG_REDUCED_BIT = 0;

  // Address field positions
  localparam int AP_BIT = 10;
  localparam int EMR2_SRF_BIT = 7;
  localparam int EMR1_RTT_LO_BIT = 2;
  localparam int EMR1_RTT_HI_BIT = 6;
  localparam int COL_TOP_BIT = 8;
  localparam int ROW_TOP_BIT = 12;

  // Mode register select by bank address
  localparam logic [1:0] SEL_MR = 2'h0;
  localparam logic [1:0] SEL_EMR1 = 2'h1;
  localparam logic [1:0] SEL_EMR2 = 2'h2;

  // Reset values
  localparam logic [12:0] MODE_RESET = 13'h0000;
  localparam logic [3:0] BANKS_IDLE = 4'h0;

  // Counts in link clock edges
  localparam logic [7:0] XSRD_CLOCKS = 8'hC8;
  localparam logic [1:0] CKE_MIN_CLOCKS = 2'h3;

endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk) begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  // Per bit: a change is accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end

endmodule

// [tb/ddr_cmd_asserts.sv]
`timescale 1ns/1ps
module ddr_cmd_asserts (
  // System
  input wire logic CLK,
  input wire logic RST,
  // Link and state
  input wire logic CKE,
  input wire logic CMD_VALID,
  input ddr_cmd_pkg::cmd_t CMD,
  input wire logic [3:0] POWER_STATE,
  input wire logic [3:0] RETAIN_BANKS,
  input wire logic ODT_ACTIVE,
  input wire logic PROTO_ERR,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////
  property p_rdy;
    PSEL && !PENABLE |=> PREADY;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_rdy_once;
    PREADY |=> !PREADY;
  endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("pready held");
  property p_unmapped;
    PSEL && !PENABLE && PADDR > 8'h10 |=> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_vld_pulse;
    CMD_VALID |=> !CMD_VALID;
  endproperty
  a_vld_pulse: assert property (p_vld_pulse) else $error("cmd valid held");
  property p_code;
    CMD_VALID |-> CMD.code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
  endproperty
  a_code: assert property (p_code) else $error("bad command code");
  property p_sr_odt;
    POWER_STATE == 4'h8 && $past(POWER_STATE) == 4'h8 |-> !ODT_ACTIVE;
  endproperty
  a_sr_odt: assert property (p_sr_odt) else $error("odt in self refresh");
  property p_retain;
    POWER_STATE != 4'h8 && $past(POWER_STATE) != 4'h8 |-> RETAIN_BANKS == 4'hF;
  endproperty
  a_retain: assert property (p_retain) else $error("data loss outside sr");
  property p_sticky;
    // Output lags the clear by one cycle, so the cycle after the write is exempt too
    PROTO_ERR && !(PSEL && PENABLE && PWRITE && PADDR == 8'h00) &&
      !$past(PSEL && PENABLE && PWRITE && PADDR == 8'h00) |=> PROTO_ERR;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error dropped");
  property p_sr_exit;
    $rose(CKE) && POWER_STATE == 4'h8 |-> ##[1:10] POWER_STATE == 4'h1;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("no sr exit");
  c_rd: cover property (CMD_VALID && CMD.code == 4'h5);
  c_sr: cover property (POWER_STATE == 4'h8);
  c_slv: cover property (PSLVERR);
endmodule

bind ddr_cmd_decode ddr_cmd_asserts u_chk (.CLK(CLK), .RST(RST), .CKE(CKE),
  .CMD_VALID(CMD_VALID), .CMD(CMD), .POWER_STATE(POWER_STATE),
  .RETAIN_BANKS(RETAIN_BANKS), .ODT_ACTIVE(ODT_ACTIVE), .PROTO_ERR(PROTO_ERR),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// [tb/ddr_ctl_model.sv]
`timescale 1ns/1ps
module ddr_ctl_model (
  // System
  input wire logic clk,
  // Memory pins
  output ddr_cmd_pkg::pins_t pins
);
  initial begin
    pins = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
  end
  ////////////////////////////////////////////////////////////////
  // One link clock period per command; clock stands still between
  task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
      input logic k, input logic [3:0] m);
    @(posedge clk);
    pins.cke <= k;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
    pins.ba <= b;
    pins.addr <= a;
    pins.dm <= m;
    // Seven here plus the edge above keep the link clock low for 40 ns before it rises
    repeat (7) @(posedge clk);
    pins.ck <= 1'b1;
    repeat (8) @(posedge clk);
    pins.ck <= 1'b0;
    // Hold time over: bank, address and mask lines no longer show the old value
    pins.ba <= ~b;
    pins.addr <= ~a;
    pins.dm <= ~m;
  endtask
  // Clock enable alone, no clock edge
  task automatic cke_set(input logic k);
    @(posedge clk);
    pins.cke <= k;
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic odt = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  ddr_cmd_pkg::pins_t p;
  ddr_cmd_pkg::cmd_t cmd, ec;
  logic cmd_valid, pready, pslverr, sr_rate, odt_act, perr, red = 1'b0;
  logic [3:0] wr_en, pstate, bopen, retain, m;
  logic [31:0] prdata;
  logic [32:0] ea;
  logic [12:0] r;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  ddr_cmd_pkg::cmd_t cq[$];
  logic [32:0] aq[$];
  always #2.5 clk = ~clk;
  ddr_ctl_model u_ctl (.clk(clk), .pins(p));
  ddr_cmd_decode uut (.CLK(clk), .RST(rst), .CK(p.ck), .CKE(p.cke), .CS_N(p.cs_n),
    .RAS_N(p.ras_n), .CAS_N(p.cas_n), .WE_N(p.we_n), .BA(p.ba), .ADDR(p.addr),
    .ODT(odt), .DM(p.dm), .CMD_VALID(cmd_valid), .CMD(cmd), .WR_BYTE_EN(wr_en),
    .POWER_STATE(pstate), .BANK_OPEN(bopen), .RETAIN_BANKS(retain),
    .SR_HIGH_RATE(sr_rate), .ODT_ACTIVE(odt_act), .PROTO_ERR(perr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e);
    if (!w) aq.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
      input logic k, input logic [3:0] d, input logic e);
    ddr_cmd_pkg::cmd_t x;
    x = ddr_cmd_pkg::cmd_t'(0);
    x.code = ddr_cmd_pkg::cmd_code_t'(c);
    x.bank = b;
    x.row = red ? a : {1'b0, a[11:0]};
    x.col = {a[8] & !red, a[7:0]};
    x.auto_pre = a[10];
    x.all_banks = a[10];
    if (e) cq.push_back(x);
    u_ctl.send(c, b, a, k, d);
  endtask
  task automatic nops(input int n, input logic k);
    repeat (n) u_ctl.send(4'h7, 2'h0, 13'h0, k, 4'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && aq.size() > 0) begin
      ea = aq.pop_front();
      chk("apb", ea, {pslverr, prdata});
    end
  end
  always @(posedge clk) begin
    if (cmd_valid === 1'b1 && cq.size() > 0) begin
      ec = cq.pop_front();
      chk("code", ec.code, cmd.code);
      chk("bank", ec.bank, cmd.bank);
      if (ec.code == 4'h3) chk("row", ec.row, cmd.row);
      if (ec.code inside {4'h4, 4'h5}) chk("col", ec.col, cmd.col);
      if (ec.code inside {4'h4, 4'h5}) chk("ap", ec.auto_pre, cmd.auto_pre);
      if (ec.code == 4'h2) chk("all", ec.all_banks, cmd.all_banks);
    end
  end
  // Run is short; a hang means a lost handshake
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hE50D));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    apb(0, 8'h00, 0, 33'h1);
    apb(0, 8'h14, 0, 33'h100000000);
    go(4'h0, 2'h2, 13'h0081, 1, 0, 1);
    go(4'h0, 2'h1, 13'h0004, 1, 0, 1);
    go(4'h0, 2'h3, 13'h1FFF, 1, 0, 1);
    chk("srate", 1, sr_rate);
    apb(0, 8'h0C, 0, 33'h81);
    apb(0, 8'h08, 0, 33'h4);
    r = 13'h1000 | 13'($urandom_range(4095));
    go(4'h3, 2'h1, r, 1, 0, 1);
    chk("open", 4'h2, bopen);
    m = 4'($urandom);
    go(4'h4, 2'h1, 13'h0005, 1, m, 1);
    chk("ben", 4'(~m), wr_en);
    odt <= 1'b1;
    nops(1, 0);
    chk("apd", 4'h4, pstate);
    chk("odt", 1, odt_act);
    nops(2, 0);
    nops(3, 1);
    chk("awake", 4'h1, pstate);
    go(4'h5, 2'h1, 13'h0500, 1, 0, 1);
    chk("closed", 4'h0, bopen);
    go(4'h2, 2'h0, 13'h0400, 1, 0, 1);
    nops(1, 0);
    chk("ppd", 4'h2, pstate);
    nops(2, 0);
    nops(3, 1);
    go(4'h1, 2'h0, 13'h0, 1, 0, 1);
    go(4'h1, 2'h0, 13'h0, 0, 0, 0);
    chk("sr", 4'h8, pstate);
    chk("keep", 4'h3, retain);
    chk("odt_sr", 0, odt_act);
    nops(2, 0);
    u_ctl.cke_set(1);
    repeat (12) @(posedge clk);
    chk("srx", 4'h1, pstate);
    nops(3, 1);
    go(4'h5, 2'h0, 13'h0, 1, 0, 1);
    repeat (4) @(posedge clk);
    chk("err", 1, perr);
    apb(0, 8'h00, 0, 33'h701);
    apb(1, 8'h10, 32'h1, 0);
    red = 1'b1;
    go(4'h3, 2'h0, 13'h1000, 1, 0, 1);
    go(4'h5, 2'h0, 13'h0100, 1, 0, 1);
    repeat (20) @(posedge clk);
    complete_run();
  end
endmodule
